/* rcfs_pkg.sv */
// Package with constants, states and carriers for the resonant controller fault sequencer
package rcfs_pkg;

   // Core clock period
   localparam int CLK_PERIOD_NS = 10;

   // Interval lengths in their own units, defaults of plain value
   localparam int VCC_BLANK_US = 20;
   localparam int PROT_BLANK_US = 20;
   localparam int STARTUP_US = 50;
   localparam int SOFTSTART_US = 500;
   localparam int RECOVERY_MS = 100;

   // Least times, rounded up to whole cycles
   localparam int VCC_BLANK_CYC = (VCC_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PROT_BLANK_CYC = (PROT_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STARTUP_CYC = (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SOFTSTART_CYC = (SOFTSTART_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVERY_CYC = (RECOVERY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Timer width and timer slots
   localparam int TIMER_W = 24;
   localparam int NUM_TIMERS = 3;
   localparam int TMR_VCC = 0;
   localparam int TMR_PROT = 1;
   localparam int TMR_PHASE = 2;

   // Sequencer states, Gray along the startup path
   typedef enum logic [3:0] {
      ST_OFF = 4'h0,
      ST_BLANK = 4'h1,
      ST_STARTUP = 4'h3,
      ST_SOFT = 4'h2,
      ST_RUN = 4'h6,
      ST_SKIP = 4'h7,
      ST_BO_WAIT = 4'h5,
      ST_REC_WAIT = 4'h4,
      ST_LATCHED = 4'hC,
      ST_FAULT_WAIT = 4'hD
   } rcfs_state_t;

   // Comparator and fault flags from the analog front end
   typedef struct packed {
      logic supply_on;
      logic supply_off;
      logic supply_reset;
      logic bulk_level_ok;
      logic fb_skip_in;
      logic fb_skip_out;
      logic overload;
      logic ovp;
      logic otp;
   } rcfs_flags_t;

   // Block bias enables
   typedef struct packed {
      logic brown_out_monitor;
      logic feedback;
      logic prot;
      logic front_stage;
      logic drive;
      logic supply_mgmt;
      logic fault_logic;
   } rcfs_bias_t;

   localparam int FLAGS_W = $bits(rcfs_flags_t);
   localparam rcfs_bias_t BIAS_NONE = 7'h00;

endpackage

/* rcfs_plant.sv */
// Model of the supply-on comparator fed by the startup source; all other flags pass through from the bench
`timescale 1ns/1ps
module rcfs_plant
   import rcfs_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic reset_n, // Reset, active low
   input wire rcfs_flags_t cmd, // Conditions set by the bench
   input wire logic startup_src_q, // Startup source charging
   output rcfs_flags_t flags_raw // Comparator flags
);
   logic [2:0] cnt_q;
   logic on_q;
   // Supply flag rises after the source charged a while, drops with it so no stale level
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !startup_src_q)
      begin
         cnt_q <= 3'h0;
         on_q <= 1'b0;
      end
      else if (startup_src_q && cnt_q != 3'h5)
         cnt_q <= cnt_q + 3'h1;
      else if (startup_src_q)
         on_q <= 1'b1;
   end
   always_comb
   begin
      flags_raw = cmd;
      flags_raw.supply_on = on_q;
   end
endmodule

/* rcfs_seq.sv */
// Operating sequence and fault state machine of the resonant converter controller
`timescale 1ns/1ps
module rcfs_seq
   import rcfs_pkg::*;
#(
   parameter int VCC_BLANK_CYCLES = VCC_BLANK_CYC,
   parameter int PROT_BLANK_CYCLES = PROT_BLANK_CYC,
   parameter int STARTUP_CYCLES = STARTUP_CYC,
   parameter int SOFTSTART_CYCLES = SOFTSTART_CYC,
   parameter int RECOVERY_CYCLES = RECOVERY_CYC
)
(
   input wire logic core_clk, // Core clock, 100 MHz
   input wire logic reset_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state when low
   input wire rcfs_flags_t flags_raw, // Asynchronous comparator flags
   output rcfs_bias_t bias_q, // Block bias enables
   output logic drv_en_q, // Gate drive outputs authorised
   output logic startup_src_q, // High-voltage startup source charging
   output logic self_supply_mode_q, // Self-supply regulation active
   output logic front_stage_control_q, // Front-stage control output at on level
   output logic soft_start_q, // Soft-start phase active
   output logic startup_phase_q, // Dedicated startup phase active
   output logic restart_pulse_q, // One-cycle pulse at each driver enable from blanking
   output rcfs_state_t state_q // Sequencer state
);

   rcfs_flags_t sync1_q;
   rcfs_flags_t sync2_q;
   rcfs_state_t state_d;
   rcfs_bias_t bias_d;
   logic drv_en_d;
   logic startup_src_d;
   logic self_supply_d;
   logic front_stage_d;
   logic first_on_q;
   logic first_on_d;
   logic hold_fb_q;
   logic hold_fb_d;
   logic restart_d;
   logic [NUM_TIMERS-1:0] tmr_load;
   logic [NUM_TIMERS-1:0] tmr_busy;
   logic [TIMER_W-1:0] tmr_period [NUM_TIMERS];
   logic [TIMER_W-1:0] phase_period;
   logic prot_fault;
   logic any_fault;

   initial
   begin
      if (VCC_BLANK_CYCLES < 1 || VCC_BLANK_CYCLES >= (1 << TIMER_W))
         $error("rcfs_seq: supply blanking count out of range");
      if (PROT_BLANK_CYCLES < 1 || PROT_BLANK_CYCLES >= (1 << TIMER_W))
         $error("rcfs_seq: protection blanking count out of range");
      if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << TIMER_W))
         $error("rcfs_seq: startup count out of range");
      if (SOFTSTART_CYCLES < 1 || SOFTSTART_CYCLES >= (1 << TIMER_W))
         $error("rcfs_seq: soft-start count out of range");
      if (RECOVERY_CYCLES < 1 || RECOVERY_CYCLES >= (1 << TIMER_W))
         $error("rcfs_seq: recovery count out of range");
   end

   // Two-stage synchroniser for the analog flags
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else if (ce)
      begin
         sync1_q <= flags_raw;
         sync2_q <= sync1_q;
      end
   end

   // Blanking, phase and recovery timers
   assign tmr_period[TMR_VCC] = TIMER_W'(VCC_BLANK_CYCLES);
   assign tmr_period[TMR_PROT] = TIMER_W'(PROT_BLANK_CYCLES);
   assign tmr_period[TMR_PHASE] = phase_period;

   generate
      for (genvar i = 0; i < NUM_TIMERS; i++)
      begin : g_tmr
         rcfs_timer #(
            .W(TIMER_W)
         ) u_tmr (
            .core_clk(core_clk),
            .reset_n(reset_n),
            .ce(ce),
            .load(tmr_load[i]),
            .period(tmr_period[i]),
            .busy(tmr_busy[i])
         );
      end
   endgenerate

   // Overvoltage always counts; overtemperature masked during protection blanking
   assign prot_fault = sync2_q.ovp || (sync2_q.otp && !tmr_busy[TMR_PROT]);
   assign any_fault = sync2_q.ovp || sync2_q.otp;

   // Next-state logic
   always_comb
   begin
      state_d = state_q;
      tmr_load = '0;
      phase_period = TIMER_W'(STARTUP_CYCLES);
      first_on_d = first_on_q;
      hold_fb_d = hold_fb_q;
      restart_d = 1'b0;
      case (state_q)
         ST_OFF:
         begin
            if (sync2_q.supply_on)
            begin
               state_d = ST_BLANK;
               tmr_load[TMR_VCC] = 1'b1;
               tmr_load[TMR_PROT] = 1'b1;
            end
         end
         ST_BLANK:
         begin
            // Faults not looked at while blanking runs
            if (!tmr_busy[TMR_VCC])
            begin
               first_on_d = 1'b0;
               if (any_fault)
                  state_d = ST_FAULT_WAIT;
               else if (!sync2_q.bulk_level_ok)
                  state_d = ST_BO_WAIT;
               else if (first_on_q && sync2_q.fb_skip_in)
               begin
                  state_d = ST_BO_WAIT;
                  hold_fb_d = 1'b1;
               end
               else
               begin
                  state_d = ST_STARTUP;
                  tmr_load[TMR_PHASE] = 1'b1;
                  restart_d = 1'b1;
               end
            end
         end
         ST_STARTUP, ST_SOFT, ST_RUN:
         begin
            if (sync2_q.overload)
            begin
               state_d = ST_REC_WAIT;
               tmr_load[TMR_PHASE] = 1'b1;
               phase_period = TIMER_W'(RECOVERY_CYCLES);
            end
            else if (prot_fault)
               state_d = ST_LATCHED;
            else if (!sync2_q.bulk_level_ok)
               state_d = ST_BO_WAIT;
            else if (state_q == ST_STARTUP)
            begin
               if (!tmr_busy[TMR_PHASE])
               begin
                  state_d = ST_SOFT;
                  tmr_load[TMR_PHASE] = 1'b1;
                  phase_period = TIMER_W'(SOFTSTART_CYCLES);
               end
            end
            else if (state_q == ST_SOFT)
            begin
               if (!tmr_busy[TMR_PHASE])
                  state_d = ST_RUN;
            end
            else if (sync2_q.fb_skip_in)
               state_d = ST_SKIP;
         end
         ST_SKIP:
         begin
            if (sync2_q.supply_off)
               state_d = ST_OFF;
            else if (sync2_q.fb_skip_out)
            begin
               state_d = ST_RUN;
               tmr_load[TMR_PROT] = 1'b1;
            end
         end
         ST_BO_WAIT:
         begin
            if (sync2_q.bulk_level_ok && (!hold_fb_q || sync2_q.fb_skip_out))
            begin
               state_d = ST_OFF;
               hold_fb_d = 1'b0;
            end
         end
         ST_REC_WAIT:
         begin
            if (!tmr_busy[TMR_PHASE])
               state_d = ST_OFF;
         end
         ST_LATCHED:
         begin
            if (sync2_q.supply_reset)
               state_d = ST_OFF;
         end
         ST_FAULT_WAIT:
         begin
            if (!any_fault)
               state_d = ST_OFF;
         end
         default:
         begin
            state_d = ST_OFF;
         end
      endcase
   end

   // Output decode from the next state so outputs leave flip-flops aligned with it
   always_comb
   begin
      bias_d = BIAS_NONE;
      drv_en_d = 1'b0;
      startup_src_d = 1'b0;
      self_supply_d = 1'b0;
      front_stage_d = 1'b0;
      case (state_d)
         ST_OFF:
         begin
            // Charging the supply capacitor from the startup source
            startup_src_d = 1'b1;
            bias_d.supply_mgmt = 1'b1;
         end
         ST_BLANK:
         begin
            bias_d.brown_out_monitor = 1'b1;
            bias_d.feedback = 1'b1;
            bias_d.prot = 1'b1;
            bias_d.front_stage = 1'b1;
            bias_d.supply_mgmt = 1'b1;
            bias_d.fault_logic = 1'b1;
            front_stage_d = 1'b1;
         end
         ST_STARTUP, ST_SOFT, ST_RUN:
         begin
            // No startup source here, also on a skip exit
            bias_d = '1;
            drv_en_d = 1'b1;
            front_stage_d = 1'b1;
         end
         ST_SKIP:
         begin
            bias_d.feedback = 1'b1;
            bias_d.supply_mgmt = 1'b1;
         end
         ST_BO_WAIT:
         begin
            bias_d.brown_out_monitor = 1'b1;
            bias_d.feedback = 1'b1;
            bias_d.front_stage = 1'b1;
            bias_d.supply_mgmt = 1'b1;
            bias_d.fault_logic = 1'b1;
            self_supply_d = 1'b1;
            front_stage_d = 1'b1;
         end
         ST_REC_WAIT:
         begin
            bias_d.feedback = 1'b1;
            bias_d.fault_logic = 1'b1;
            self_supply_d = 1'b1;
         end
         ST_LATCHED:
         begin
            bias_d.feedback = 1'b1;
            bias_d.supply_mgmt = 1'b1;
            self_supply_d = 1'b1;
         end
         ST_FAULT_WAIT:
         begin
            bias_d.brown_out_monitor = 1'b1;
            bias_d.feedback = 1'b1;
            bias_d.prot = 1'b1;
            bias_d.front_stage = 1'b1;
            bias_d.supply_mgmt = 1'b1;
            bias_d.fault_logic = 1'b1;
            self_supply_d = 1'b1;
            front_stage_d = 1'b1;
         end
         default:
         begin
            bias_d = BIAS_NONE;
         end
      endcase
   end

   // State and sequence memory
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         state_q <= ST_OFF;
         first_on_q <= 1'b1;
         hold_fb_q <= 1'b0;
      end
      else if (ce)
      begin
         state_q <= state_d;
         first_on_q <= first_on_d;
         hold_fb_q <= hold_fb_d;
      end
   end

   // Registered outputs
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         bias_q <= BIAS_NONE;
         drv_en_q <= 1'b0;
         startup_src_q <= 1'b0;
         self_supply_mode_q <= 1'b0;
         front_stage_control_q <= 1'b0;
         soft_start_q <= 1'b0;
         startup_phase_q <= 1'b0;
         restart_pulse_q <= 1'b0;
      end
      else if (ce)
      begin
         bias_q <= bias_d;
         drv_en_q <= drv_en_d;
         startup_src_q <= startup_src_d;
         self_supply_mode_q <= self_supply_d;
         front_stage_control_q <= front_stage_d;
         soft_start_q <= (state_d == ST_SOFT);
         startup_phase_q <= (state_d == ST_STARTUP);
         restart_pulse_q <= restart_d;
      end
   end

endmodule

/* rcfs_seq_chk.sv */
// Port assertions for the fault sequencer, bound to its top module
`timescale 1ns/1ps
module rcfs_seq_chk
   import rcfs_pkg::*;
(
   input wire logic core_clk, // Core clock
   input wire logic reset_n, // Reset, active low
   input wire rcfs_bias_t bias_q, // Bias enables
   input wire logic drv_en_q, // Drive authorised
   input wire logic startup_src_q, // Startup source charging
   input wire logic self_supply_mode_q, // Self-supply active
   input wire logic front_stage_control_q, // Front stage at on level
   input wire logic restart_pulse_q, // Restart pulse
   input wire rcfs_state_t state_q // Sequencer state
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   blank_hold_a: assert property ((state_q == ST_BLANK && $past(state_q) != ST_BLANK) |-> ##1 (state_q == ST_BLANK) [*3])
      else $error("blanking ended early");
   blank_bias_a: assert property ((state_q == ST_BLANK && $past(state_q) == ST_OFF) |-> bias_q == 7'h7B && front_stage_control_q)
      else $error("blocks not biased at supply-on");
   drive_auth_a: assert property (drv_en_q |-> state_q inside {ST_STARTUP, ST_SOFT, ST_RUN})
      else $error("drive outside driving states");
   restart_entry_a: assert property (restart_pulse_q |-> state_q == ST_STARTUP && $past(state_q) == ST_BLANK ##1 !restart_pulse_q)
      else $error("restart pulse wrong");
   soft_order_a: assert property ((state_q == ST_SOFT && $past(state_q) != ST_SOFT) |-> $past(state_q) == ST_STARTUP)
      else $error("soft-start not after startup phase");
   skip_bias_a: assert property (state_q == ST_SKIP |-> bias_q == 7'h22 && !drv_en_q)
      else $error("skip bias wrong");
   skip_exit_a: assert property (($past(state_q) == ST_SKIP && state_q == ST_RUN) |-> bias_q == 7'h7F && drv_en_q && !startup_src_q)
      else $error("skip exit wrong");
   rec_bias_a: assert property (state_q == ST_REC_WAIT |-> bias_q == 7'h21 && self_supply_mode_q && !drv_en_q)
      else $error("recovery wait bias wrong");
   rec_exit_a: assert property (($past(state_q) == ST_REC_WAIT && state_q != ST_REC_WAIT) |-> state_q == ST_OFF && startup_src_q)
      else $error("recovery exit wrong");
   bo_wait_a: assert property (state_q == ST_BO_WAIT |-> !drv_en_q && !bias_q.prot && self_supply_mode_q && front_stage_control_q)
      else $error("brown-out wait wrong");
   latch_hold_a: assert property (state_q == ST_LATCHED |=> state_q inside {ST_LATCHED, ST_OFF})
      else $error("latch left wrongly");
endmodule

bind rcfs_seq rcfs_seq_chk u_chk (.core_clk(core_clk), .reset_n(reset_n), .bias_q(bias_q), .drv_en_q(drv_en_q),
   .startup_src_q(startup_src_q), .self_supply_mode_q(self_supply_mode_q),
   .front_stage_control_q(front_stage_control_q), .restart_pulse_q(restart_pulse_q), .state_q(state_q));

/* rcfs_seq_test.sv */
// Self-checking testbench of the fault sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module rcfs_seq_test;
   import rcfs_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   logic ce = 1'b1;
   rcfs_flags_t c;
   rcfs_flags_t flags_raw;
   rcfs_bias_t bias_q;
   rcfs_state_t state_q;
   logic drv_en_q, startup_src_q, self_q, front_q, soft_q, phase_q, pulse_q;
   int errors = 0;
   int n_compared = 0;
   int waited;

   always #5 core_clk = ~core_clk;

   rcfs_plant plant (.core_clk(core_clk), .reset_n(reset_n), .cmd(c), .startup_src_q(startup_src_q),
      .flags_raw(flags_raw));
   rcfs_seq #(.VCC_BLANK_CYCLES(4), .PROT_BLANK_CYCLES(4), .STARTUP_CYCLES(4), .SOFTSTART_CYCLES(6),
      .RECOVERY_CYCLES(10)) dut (.core_clk(core_clk), .reset_n(reset_n), .ce(ce), .flags_raw(flags_raw),
      .bias_q(bias_q), .drv_en_q(drv_en_q), .startup_src_q(startup_src_q), .self_supply_mode_q(self_q),
      .front_stage_control_q(front_q), .soft_start_q(soft_q), .startup_phase_q(phase_q),
      .restart_pulse_q(pulse_q), .state_q(state_q));

   task automatic wait_st(input rcfs_state_t s);
      int i;
      for (i = 0; i < 60 && state_q !== s; i++)
         @(negedge core_clk);
      waited = i;
      `CHK(state_q, s)
   endtask

   task automatic t_first_on();
      wait_st(ST_BLANK);
      `CHK(bias_q, 7'h7B)
      `CHK(front_q, 1'b1)
      wait_st(ST_BO_WAIT);
      `CHK(drv_en_q, 1'b0)
      c.fb_skip_in = 1'b0;
      c.fb_skip_out = 1'b1;
      wait_st(ST_OFF);
      wait_st(ST_BLANK);
      c.fb_skip_out = 1'b0;
      c.ovp = 1'b1;
      @(negedge core_clk);
      c.ovp = 1'b0;
      wait_st(ST_STARTUP);
   endtask

   task automatic t_startup();
      `CHK(pulse_q, 1'b1)
      `CHK(drv_en_q, 1'b1)
      `CHK(phase_q, 1'b1)
      wait_st(ST_SOFT);
      `CHK(soft_q, 1'b1)
      wait_st(ST_RUN);
   endtask

   task automatic t_skip();
      c.fb_skip_in = 1'b1;
      wait_st(ST_SKIP);
      `CHK(bias_q, 7'h22)
      c.fb_skip_in = 1'b0;
      c.fb_skip_out = 1'b1;
      c.otp = 1'b1;
      wait_st(ST_RUN);
      c.otp = 1'b0;
      `CHK(startup_src_q, 1'b0)
      `CHK(drv_en_q, 1'b1)
      repeat (8) @(negedge core_clk);
      `CHK(state_q, ST_RUN)
      c.fb_skip_out = 1'b0;
      c.fb_skip_in = 1'b1;
      wait_st(ST_SKIP);
      c.fb_skip_in = 1'b0;
      c.supply_off = 1'b1;
      wait_st(ST_OFF);
      c.supply_off = 1'b0;
      wait_st(ST_RUN);
   endtask

   task automatic t_brownout();
      c.bulk_level_ok = 1'b0;
      wait_st(ST_BO_WAIT);
      `CHK(drv_en_q, 1'b0)
      `CHK(bias_q.prot, 1'b0)
      `CHK(self_q, 1'b1)
      `CHK(front_q, 1'b1)
      c.bulk_level_ok = 1'b1;
      wait_st(ST_OFF);
      wait_st(ST_STARTUP);
      wait_st(ST_RUN);
   endtask

   task automatic t_overload();
      c.overload = 1'b1;
      wait_st(ST_REC_WAIT);
      `CHK(bias_q, 7'h21)
      `CHK(self_q, 1'b1)
      c.overload = 1'b0;
      c.ovp = 1'b1;
      wait_st(ST_OFF);
      `CHK(waited >= 10, 1'b1)
      `CHK(startup_src_q, 1'b1)
      wait_st(ST_FAULT_WAIT);
      `CHK(drv_en_q, 1'b0)
      c.ovp = 1'b0;
      wait_st(ST_OFF);
      `CHK(startup_src_q, 1'b1)
      wait_st(ST_RUN);
   endtask

   task automatic t_latch();
      c.ovp = 1'b1;
      wait_st(ST_LATCHED);
      `CHK(bias_q, 7'h22)
      c.ovp = 1'b0;
      repeat (5) @(negedge core_clk);
      `CHK(state_q, ST_LATCHED)
      // Clock enable low must freeze the latch release
      ce = 1'b0;
      c.supply_reset = 1'b1;
      repeat (6) @(negedge core_clk);
      `CHK(state_q, ST_LATCHED)
      `CHK(self_q, 1'b1)
      ce = 1'b1;
      wait_st(ST_OFF);
      c.supply_reset = 1'b0;
   endtask

   task automatic give_verdict();
      $display("Compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      c = '0;
      c.bulk_level_ok = 1'b1;
      c.fb_skip_in = 1'b1;
      repeat (10) @(negedge core_clk);
      reset_n = 1'b1;
      t_first_on();
      t_startup();
      t_skip();
      t_brownout();
      t_overload();
      t_latch();
      give_verdict();
   end

   // Whole run takes well under 2000 cycles
   initial
   begin
      #200000;
      errors++;
      give_verdict();
   end
endmodule

/* rcfs_timer.sv */
// Loadable down-counter used for blanking and delay intervals
`timescale 1ns/1ps
module rcfs_timer
   import rcfs_pkg::*;
#(
   parameter int W = TIMER_W
)
(
   input wire logic core_clk, // Core clock
   input wire logic reset_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic load, // Start interval
   input wire logic [W-1:0] period, // Interval length in cycles
   output logic busy // Interval running
);

   logic [W-1:0] cnt_q;

   initial
   begin
      if (W < 2)
         $error("rcfs_timer: width too small");
   end

   // Down-counter, reload wins over counting
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         cnt_q <= '0;
      else if (ce)
      begin
         if (load)
            cnt_q <= period;
         else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   assign busy = (cnt_q != '0);

endmodule
